// [endpoint_buffer_access.sv]
/*
 * Endpoint buffer management and FIFO access of a USB device controller.
 * Assumes the serial engine and the microcontroller port run on i_sys_clk.
 */
`timescale 1ns/1ps
`include "endpoint_buffer_params.svh"

module endpoint_buffer_access (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Microcontroller register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_bus16,
    output logic [15:0] o_reg_rdata,
    // Endpoint selection and configuration
    input wire logic [3:0] i_endpoint_select_index,
    input wire logic i_ep_dir,
    input wire logic i_setup_buffer_select,
    input wire logic [`EBA_MPS_W-1:0] i_max_packet_limit,
    input wire logic i_mps_write,
    input wire logic [`EBA_NUM_EP-1:0] i_suppress_zero_length_packet,
    input wire logic [`EBA_NUM_EP-1:0] i_iso_ep,
    // Serial engine side
    input wire logic i_usb_bus_reset,
    input wire endpoint_buffer_pkg::token_type i_token,
    input wire logic i_rx_wr,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_commit,
    input wire logic i_tx_rd,
    input wire logic i_in_acked,
    output logic [7:0] o_tx_byte,
    output endpoint_buffer_pkg::answer_type o_answer
);

////////////////////////////////////////////////////////////////////////////////

localparam int MEM_W = `EBA_BUF_W + `EBA_DEPTH_W;
localparam int SLOTS = `EBA_NUM_BUF << `EBA_DEPTH_W;
localparam logic [`EBA_PTR_W-1:0] PTR_ONE = `EBA_PTR_W'(1);
localparam logic [`EBA_CNT_W-1:0] CNT_ONE = `EBA_CNT_W'(1);
localparam logic [`EBA_CNT_W-1:0] CNT_TWO = `EBA_CNT_W'(2);

endpoint_buffer_pkg::state_type s_ff;
endpoint_buffer_pkg::state_type nxt_s;
logic [7:0] mem [SLOTS];
logic [`EBA_BUF_W-1:0] sel;
logic rx_sel;
logic ctrl_wr;
logic data_wr;
logic data_rd;
logic cnt_wr;
logic we_lo;
logic we_hi;
logic [MEM_W-1:0] a_lo;
logic [MEM_W-1:0] a_hi;
logic [MEM_W-1:0] a_rx;
logic [7:0] c;

function automatic logic [MEM_W-1:0] slot(input logic [`EBA_BUF_W-1:0] b, input logic [`EBA_PTR_W-1:0] p);
    slot = {b, p[`EBA_DEPTH_W-1:0]};
endfunction

////////////////////////////////////////////////////////////////////////////////

// Selection is sampled live; software sets it before each access
assign sel = i_setup_buffer_select ? `EBA_SETUP_BUF : {1'b0, i_endpoint_select_index, i_ep_dir};
assign rx_sel = i_setup_buffer_select || !i_ep_dir;
assign ctrl_wr = i_reg_wr && (i_reg_addr == `EBA_OFS_CTRL);
assign data_wr = i_reg_wr && (i_reg_addr == `EBA_OFS_DATA);
assign data_rd = i_reg_rd && (i_reg_addr == `EBA_OFS_DATA);
assign cnt_wr = i_reg_wr && (i_reg_addr == `EBA_OFS_COUNT);
assign c = i_reg_wdata[7:0];

// Upper byte never written in 8-bit bus mode
assign we_lo = data_wr && !rx_sel;
assign we_hi = we_lo && i_bus16;
assign a_lo = slot(sel, s_ff.wptr[sel]);
assign a_hi = slot(sel, s_ff.wptr[sel] + PTR_ONE);
assign a_rx = slot(s_ff.sie_buf, s_ff.wptr[s_ff.sie_buf]);

always_ff @(posedge i_sys_clk) begin
    if (we_lo) begin
        mem[a_lo] <= i_reg_wdata[7:0];
    end
    if (we_hi) begin
        mem[a_hi] <= i_reg_wdata[15:8];
    end
    if (i_rx_wr) begin
        mem[a_rx] <= i_rx_byte;
    end
end

////////////////////////////////////////////////////////////////////////////////

always_comb begin
    logic [`EBA_BUF_W-1:0] b;
    logic [`EBA_PTR_W-1:0] fill;
    logic [`EBA_CNT_W-1:0] cnt;
    logic [`EBA_CNT_W-1:0] step;
    logic [`EBA_CNT_W-1:0] mps;
    logic [`EBA_MPS_W-1:0] len;
    b = sel;
    fill = '0;
    cnt = '0;
    step = '0;
    len = '0;
    mps = `EBA_CNT_W'(i_max_packet_limit);
    nxt_s = s_ff;
    nxt_s.answer.valid = 1'b0;

    // Reads answer one cycle later; unmapped offsets read zero
    if (i_reg_rd) begin
        nxt_s.rdata = 16'h0000;
        if (i_reg_addr == `EBA_OFS_COUNT) begin
            nxt_s.rdata = s_ff.count[sel];
        end else if (i_reg_addr == `EBA_OFS_CTRL) begin
            nxt_s.rdata[`EBA_BIT_STALL] = s_ff.stall[sel];
            nxt_s.rdata[`EBA_BIT_STATUS] = s_ff.status_ack && (i_endpoint_select_index == 4'h0);
        end else if (data_rd && rx_sel && s_ff.count[sel] != '0) begin
            cnt = s_ff.count[sel];
            step = (i_bus16 && cnt >= CNT_TWO) ? CNT_TWO : CNT_ONE;
            nxt_s.rdata[7:0] = mem[slot(sel, s_ff.rptr[sel])];
            // Odd tail byte sits on the low lane, high lane reads zero
            if (step == CNT_TWO) begin
                nxt_s.rdata[15:8] = mem[slot(sel, s_ff.rptr[sel] + PTR_ONE)];
            end
            nxt_s.count[sel] = cnt - step;
            nxt_s.rptr[sel] = s_ff.rptr[sel] + `EBA_PTR_W'(step);
            if (cnt == step) begin
                nxt_s.ready[sel] = 1'b0;
                nxt_s.wptr[sel] = '0;
                nxt_s.rptr[sel] = '0;
            end
        end
    end

    if (cnt_wr) begin
        nxt_s.count[sel] = i_reg_wdata;
    end

    if (we_lo) begin
        nxt_s.wptr[sel] = s_ff.wptr[sel] + (i_bus16 ? `EBA_PTR_W'(2) : PTR_ONE);
    end

    // Only bits 4, 3, 1, 0 act; the rest are dropped
    if (ctrl_wr) begin
        if (c[`EBA_BIT_CLEAR] && rx_sel) begin
            nxt_s.ready[sel] = 1'b0;
            nxt_s.wptr[sel] = '0;
            nxt_s.rptr[sel] = '0;
            nxt_s.count[sel] = `EBA_CNT_RESET;
        end
        if (c[`EBA_BIT_VALIDATE] && !rx_sel) begin
            nxt_s.ready[sel] = 1'b1;
        end
        if (i_endpoint_select_index == 4'h0) begin
            nxt_s.status_ack = c[`EBA_BIT_STATUS];
        end
        // Isochronous endpoints never stall
        nxt_s.stall[sel] = c[`EBA_BIT_STALL] && !i_iso_ep[i_endpoint_select_index];
    end

    // Token answers, one cycle after the token
    if (i_token.setup_tok) begin
        nxt_s.sie_buf = `EBA_SETUP_BUF;
        nxt_s.ready[`EBA_SETUP_BUF] = 1'b0;
        nxt_s.wptr[`EBA_SETUP_BUF] = '0;
        nxt_s.rptr[`EBA_SETUP_BUF] = '0;
        nxt_s.status_ack = 1'b0;
        nxt_s.answer = '{1'b1, endpoint_buffer_pkg::resp_ack, '0};
    end else if (i_token.in_tok) begin
        b = {1'b0, i_token.ep, 1'b1};
        fill = s_ff.wptr[b] - s_ff.rptr[b];
        nxt_s.sie_buf = b;
        nxt_s.answer.valid = 1'b1;
        nxt_s.answer.len = '0;
        if (s_ff.stall[b]) begin
            nxt_s.answer.code = endpoint_buffer_pkg::resp_stall;
        end else if (i_token.ep == 4'h0 && i_token.status_stage) begin
            nxt_s.answer.code = s_ff.status_ack ? endpoint_buffer_pkg::resp_data : endpoint_buffer_pkg::resp_nak;
            nxt_s.status_ack = 1'b0;
        end else if (s_ff.ready[b]) begin
            len = (`EBA_CNT_W'(fill) >= mps) ? i_max_packet_limit : `EBA_MPS_W'(fill);
            nxt_s.answer.code = endpoint_buffer_pkg::resp_data;
            nxt_s.answer.len = len;
        end else if (s_ff.zlp[b]) begin
            nxt_s.answer.code = endpoint_buffer_pkg::resp_data;
        end else begin
            nxt_s.answer.code = endpoint_buffer_pkg::resp_nak;
        end
        nxt_s.sie_len = len;
    end else if (i_token.out_tok) begin
        b = {1'b0, i_token.ep, 1'b0};
        nxt_s.sie_buf = b;
        nxt_s.answer.valid = 1'b1;
        nxt_s.answer.len = '0;
        if (s_ff.stall[b]) begin
            nxt_s.answer.code = endpoint_buffer_pkg::resp_stall;
        end else if (i_token.ep == 4'h0 && i_token.status_stage) begin
            nxt_s.answer.code = s_ff.status_ack ? endpoint_buffer_pkg::resp_ack : endpoint_buffer_pkg::resp_nak;
            nxt_s.status_ack = 1'b0;
        end else if (s_ff.ready[b]) begin
            nxt_s.answer.code = endpoint_buffer_pkg::resp_nak;
        end else begin
            nxt_s.answer.code = endpoint_buffer_pkg::resp_ack;
        end
    end

    // Serial engine path: bytes land in and are read out of the latched buffer
    b = s_ff.sie_buf;
    if (i_rx_wr) begin
        nxt_s.wptr[b] = nxt_s.wptr[b] + PTR_ONE;
    end
    if (i_rx_commit) begin
        nxt_s.count[b] = `EBA_CNT_W'(nxt_s.wptr[b] - nxt_s.rptr[b]);
        nxt_s.ready[b] = 1'b1;
    end
    if (i_tx_rd) begin
        nxt_s.tx_byte = mem[slot(b, s_ff.rptr[b])];
        nxt_s.rptr[b] = nxt_s.rptr[b] + PTR_ONE;
    end
    if (i_in_acked) begin
        cnt = s_ff.count[b];
        cnt = (cnt > `EBA_CNT_W'(s_ff.sie_len)) ? cnt - `EBA_CNT_W'(s_ff.sie_len) : '0;
        nxt_s.count[b] = cnt;
        nxt_s.ready[b] = 1'b0;
        nxt_s.zlp[b] = (s_ff.sie_len != '0) && (cnt == '0) && !i_suppress_zero_length_packet[b[4:1]];
    end

    // Auto-validation only runs while the counter holds a count
    for (int e = 0; e < `EBA_NUM_EP; e++) begin
        b = `EBA_BUF_W'(2 * e + 1);
        fill = nxt_s.wptr[b] - nxt_s.rptr[b];
        cnt = nxt_s.count[b];
        if (!nxt_s.ready[b] && mps != '0 && cnt != '0 &&
            (`EBA_CNT_W'(fill) >= mps || (cnt < mps && `EBA_CNT_W'(fill) >= cnt))) begin
            nxt_s.ready[b] = 1'b1;
        end
    end

    if (i_mps_write) begin
        for (int e = 0; e < `EBA_NUM_BUF; e++) begin
            nxt_s.count[e] = mps;
        end
    end

    if (i_usb_bus_reset) begin
        nxt_s.count = '0;
        nxt_s.ready = '0;
        nxt_s.stall = '0;
        nxt_s.zlp = '0;
        nxt_s.wptr = '0;
        nxt_s.rptr = '0;
        nxt_s.status_ack = 1'b0;
    end
end

always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
        s_ff <= '0;
    end else begin
        s_ff <= nxt_s;
    end
end

assign o_reg_rdata = s_ff.rdata;
assign o_tx_byte = s_ff.tx_byte;
assign o_answer = s_ff.answer;

////////////////////////////////////////////////////////////////////////////////

default clocking cb @(posedge i_sys_clk);
endclocking
default disable iff (i_rst);
stall_answer_a: assert property (
    i_token.in_tok && !i_token.setup_tok && s_ff.stall[{1'b0, i_token.ep, 1'b1}]
    |=> o_answer.valid && o_answer.code == endpoint_buffer_pkg::resp_stall)
    else $error("stalled IN endpoint did not answer STALL");
old_data_nak_a: assert property (
    i_token.out_tok && !i_token.in_tok && !i_token.setup_tok && !i_token.status_stage
    && s_ff.ready[{1'b0, i_token.ep, 1'b0}] && !s_ff.stall[{1'b0, i_token.ep, 1'b0}]
    |=> o_answer.code == endpoint_buffer_pkg::resp_nak)
    else $error("full OUT buffer accepted a packet");
clear_rx_a: assert property (
    ctrl_wr && c[`EBA_BIT_CLEAR] && rx_sel && !i_rx_commit |=> !s_ff.ready[$past(sel)])
    else $error("clear left receive buffer holding data");
clear_keeps_tx_a: assert property (
    ctrl_wr && c[`EBA_BIT_CLEAR] && !rx_sel && !i_in_acked && !i_rx_commit && !i_mps_write
    && !i_usb_bus_reset && !i_reg_rd |=> $stable(s_ff.count))
    else $error("clear disturbed a transmit count");
validate_tx_a: assert property (
    ctrl_wr && c[`EBA_BIT_VALIDATE] && !rx_sel && !i_in_acked && !i_usb_bus_reset
    |=> s_ff.ready[$past(sel)])
    else $error("validate did not ready transmit buffer");
status_setup_a: assert property (
    i_token.setup_tok |=> !s_ff.status_ack ##1 !s_ff.status_ack || $past(ctrl_wr))
    else $error("status bit survived a SETUP token");
bus_reset_a: assert property (
    i_usb_bus_reset |=> s_ff.count == '0 && s_ff.ready == '0)
    else $error("bus reset left a nonzero byte count");
mps_load_a: assert property (
    i_mps_write && !i_usb_bus_reset |=> s_ff.count[0] == `EBA_CNT_W'($past(i_max_packet_limit)))
    else $error("packet limit write did not reload counter");
read_step_a: assert property (
    data_rd && rx_sel && i_bus16 && s_ff.count[sel] >= CNT_TWO && !i_rx_commit && !i_mps_write
    && !i_usb_bus_reset && !i_in_acked
    |=> s_ff.count[$past(sel)] == $past(s_ff.count[sel]) - CNT_TWO)
    else $error("16-bit read did not step count by two");

endmodule

// [endpoint_buffer_params.svh]
/*
 * Offsets, bit positions, sizes and reset values of the endpoint buffer block.
 * Assumes it is included by bare name; definitions only.
 */
`ifndef ENDPOINT_BUFFER_PARAMS_SVH
`define ENDPOINT_BUFFER_PARAMS_SVH

// Register offsets on the microcontroller port
`define EBA_OFS_COUNT 8'h1C
`define EBA_OFS_DATA 8'h20
`define EBA_OFS_CTRL 8'h28

// Control byte bit positions
`define EBA_BIT_STALL 0
`define EBA_BIT_STATUS 1
`define EBA_BIT_VALIDATE 3
`define EBA_BIT_CLEAR 4

// Buffers: two per endpoint plus the setup buffer
`define EBA_NUM_EP 16
`define EBA_NUM_BUF 33
`define EBA_BUF_W 6
`define EBA_SETUP_BUF 6'h20
`define EBA_DEPTH_W 6
`define EBA_PTR_W 7
`define EBA_MPS_W 11
`define EBA_CNT_W 16
`define EBA_CNT_RESET 16'h0000

`endif

// [endpoint_buffer_pkg.sv]
/*
 * Types shared by the endpoint buffer block: token and answer carriers, state.
 * Assumes the params header is on the include path.
 */
package endpoint_buffer_pkg;
`include "endpoint_buffer_params.svh"

    typedef enum logic [1:0] {
        resp_nak,
        resp_ack,
        resp_data,
        resp_stall
    } resp_code_type;

    typedef struct packed {
        logic in_tok;
        logic out_tok;
        logic setup_tok;
        logic status_stage;
        logic [3:0] ep;
    } token_type;

    typedef struct packed {
        logic valid;
        resp_code_type code;
        logic [`EBA_MPS_W-1:0] len;
    } answer_type;

    typedef struct packed {
        logic [`EBA_NUM_BUF-1:0][`EBA_CNT_W-1:0] count;
        logic [`EBA_NUM_BUF-1:0][`EBA_PTR_W-1:0] wptr;
        logic [`EBA_NUM_BUF-1:0][`EBA_PTR_W-1:0] rptr;
        logic [`EBA_NUM_BUF-1:0] ready;
        logic [`EBA_NUM_BUF-1:0] stall;
        logic [`EBA_NUM_BUF-1:0] zlp;
        logic status_ack;
        logic [`EBA_BUF_W-1:0] sie_buf;
        logic [`EBA_MPS_W-1:0] sie_len;
        answer_type answer;
        logic [15:0] rdata;
        logic [7:0] tx_byte;
    } state_type;

endpackage

// [usb_host_model.sv]
/*
 * Behavioural USB host plus serial engine facing the endpoint buffers.
 * Assumes the bench calls one task at a time, all on i_sys_clk.
 */
`timescale 1ns/1ps
module usb_host_model (
    // Clock
    input wire logic i_sys_clk,
    // From the block
    input wire endpoint_buffer_pkg::answer_type i_answer,
    input wire logic [7:0] i_tx_byte,
    // To the block
    output endpoint_buffer_pkg::token_type o_token,
    output logic o_rx_wr,
    output logic [7:0] o_rx_byte,
    output logic o_rx_commit,
    output logic o_tx_rd,
    output logic o_in_acked
);
    initial begin
        o_token = '0;
        o_rx_wr = 1'b0;
        o_rx_byte = 8'h00;
        o_rx_commit = 1'b0;
        o_tx_rd = 1'b0;
        o_in_acked = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic tok(input logic [3:0] k, input logic [3:0] e, output endpoint_buffer_pkg::answer_type ans);
        @(posedge i_sys_clk);
        o_token <= {k, e};
        @(posedge i_sys_clk);
        o_token <= '0;
        #1;
        ans = i_answer;
    endtask
    // Only called after an ACK, so a full buffer never sees data
    task automatic rx(input logic [7:0] q[$], input logic slow);
        foreach (q[i]) begin
            @(posedge i_sys_clk);
            o_rx_wr <= 1'b1;
            o_rx_byte <= q[i];
            if (slow) begin
                @(posedge i_sys_clk);
                o_rx_wr <= 1'b0;
            end
        end
        @(posedge i_sys_clk);
        o_rx_wr <= 1'b0;
        // Stale lane would hide a missed strobe
        o_rx_byte <= ~o_rx_byte;
        o_rx_commit <= 1'b1;
        @(posedge i_sys_clk);
        o_rx_commit <= 1'b0;
    endtask
    task automatic tx(input int n, output logic [7:0] got[$]);
        for (int i = 0; i < n; i++) begin
            @(posedge i_sys_clk);
            o_tx_rd <= 1'b1;
            @(posedge i_sys_clk);
            o_tx_rd <= 1'b0;
            #1;
            got.push_back(i_tx_byte);
        end
    endtask
    task automatic ack_in();
        @(posedge i_sys_clk);
        o_in_acked <= 1'b1;
        @(posedge i_sys_clk);
        o_in_acked <= 1'b0;
    endtask
endmodule

// [endpoint_buffer_access_tb_top.sv]
/*
 * Self-checking bench of the endpoint buffer block with a host model.
 * Assumes the params header and package are compiled first.
 */
`timescale 1ns/1ps
`include "endpoint_buffer_params.svh"
module endpoint_buffer_access_tb_top;
    localparam logic [7:0] CNT = `EBA_OFS_COUNT;
    localparam logic [7:0] DAT_P = `EBA_OFS_DATA;
    localparam logic [7:0] CTL = `EBA_OFS_CTRL;
    localparam logic [3:0] K_IN = 4'h8;
    localparam logic [3:0] K_OUT = 4'h4;
    localparam logic [1:0] NAK = 2'h0;
    localparam logic [1:0] ACK = 2'h1;
    localparam logic [1:0] DAT = 2'h2;
    localparam logic [1:0] STL = 2'h3;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic bus16 = 1'b1;
    logic [15:0] rdata;
    logic [3:0] ep_sel = 4'h0;
    logic ep_dir = 1'b0;
    logic setup_sel = 1'b0;
    logic [`EBA_MPS_W-1:0] mps = 11'h008;
    logic mps_wr = 1'b0;
    logic [15:0] no_zlp = 16'h0008;
    logic [15:0] iso = 16'h0020;
    logic bus_reset = 1'b0;
    endpoint_buffer_pkg::token_type token;
    endpoint_buffer_pkg::answer_type answer;
    endpoint_buffer_pkg::answer_type a;
    logic rx_wr, rx_commit, tx_rd, in_acked;
    logic [7:0] rx_byte, tx_byte;
    logic [7:0] addrs[4] = '{8'h1C, 8'h20, 8'h28, 8'h30};
    logic [7:0] q[$];
    logic [15:0] v;
    int num_errors = 0;
    int checked = 0;
    always #2.5 i_sys_clk = ~i_sys_clk;
    endpoint_buffer_access uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr_s),
        .i_reg_rd(rd_s), .i_reg_wdata(wdata), .i_bus16(bus16), .o_reg_rdata(rdata),
        .i_endpoint_select_index(ep_sel), .i_ep_dir(ep_dir), .i_setup_buffer_select(setup_sel),
        .i_max_packet_limit(mps), .i_mps_write(mps_wr), .i_suppress_zero_length_packet(no_zlp),
        .i_iso_ep(iso), .i_usb_bus_reset(bus_reset), .i_token(token), .i_rx_wr(rx_wr),
        .i_rx_byte(rx_byte), .i_rx_commit(rx_commit), .i_tx_rd(tx_rd), .i_in_acked(in_acked),
        .o_tx_byte(tx_byte), .o_answer(answer));
    usb_host_model host (.i_sys_clk(i_sys_clk), .i_answer(answer), .i_tx_byte(tx_byte), .o_token(token),
        .o_rx_wr(rx_wr), .o_rx_byte(rx_byte), .o_rx_commit(rx_commit), .o_tx_rd(tx_rd),
        .o_in_acked(in_acked));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tk(input logic [3:0] k, input logic [3:0] e, input logic [1:0] c, input logic [10:0] n);
        host.tok(k, e, a);
        check({13'h0000, a.valid, a.code}, {13'h0001, c});
        if (c == DAT) begin
            check({5'h00, a.len}, {5'h00, n});
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        @(posedge i_sys_clk);
        addr <= ad;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge i_sys_clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [15:0] exp);
        @(posedge i_sys_clk);
        addr <= ad;
        rd_s <= 1'b1;
        @(posedge i_sys_clk);
        rd_s <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic sel(input logic [3:0] e, input logic d);
        @(posedge i_sys_clk);
        ep_sel <= e;
        ep_dir <= d;
    endtask
    task automatic auto_in(input logic [3:0] e, input int total);
        int rem;
        int len;
        logic [7:0] got[$];
        rem = total;
        q = {};
        sel(e, 1'b1);
        wr(CNT, 16'(total));
        for (int i = 0; i < total; i += 2) begin
            q.push_back(8'($urandom));
            q.push_back(8'($urandom));
            wr(DAT_P, {q[i + 1], q[i]});
        end
        while (rem > 0) begin
            len = (rem < mps) ? rem : mps;
            tk(K_IN, e, DAT, 11'(len));
            host.tx(len, got);
            foreach (got[i]) begin
                check({8'h00, got[i]}, {8'h00, q.pop_front()});
            end
            host.ack_in();
            rem -= len;
            rd(CNT, 16'(rem));
        end
        tk(K_IN, e, no_zlp[e] ? NAK : DAT, 11'h000);
    endtask
    task automatic test_done();
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        num_errors++;
        test_done();
    end
    initial begin
        void'($urandom(45));
        repeat (16) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        sel(4'h1, 1'b0);
        foreach (addrs[i]) begin
            rd(addrs[i], 16'h0000);
        end
        @(posedge i_sys_clk);
        mps_wr <= 1'b1;
        @(posedge i_sys_clk);
        mps_wr <= 1'b0;
        for (int e = 0; e < 16; e += 5) begin
            sel(4'(e), e[0]);
            rd(CNT, 16'h0008);
        end
        sel(4'h1, 1'b0);
        wr(CNT, 16'h1234);
        rd(CNT, 16'h1234);
        @(posedge i_sys_clk);
        bus_reset <= 1'b1;
        @(posedge i_sys_clk);
        bus_reset <= 1'b0;
        rd(CNT, 16'h0000);
        // Transmit bytes parked in ep1 while its receive side is cleared
        sel(4'h1, 1'b1);
        wr(DAT_P, 16'hB2A1);
        bus16 <= 1'b0;
        wr(DAT_P, 16'hFFC3);
        bus16 <= 1'b1;
        sel(4'h1, 1'b0);
        tk(K_OUT, 4'h1, ACK, 11'h000);
        q = {};
        repeat (5) q.push_back(8'($urandom));
        host.rx(q, 1'b1);
        rd(CNT, 16'h0005);
        tk(K_OUT, 4'h1, NAK, 11'h000);
        while (q.size() > 1) begin
            v = {q[1], q[0]};
            q = q[2:$];
            rd(DAT_P, v);
            rd(CNT, 16'(q.size()));
        end
        rd(DAT_P, {8'h00, q.pop_front()});
        tk(K_OUT, 4'h1, ACK, 11'h000);
        repeat (3) q.push_back(8'($urandom));
        host.rx(q, 1'b0);
        bus16 <= 1'b0;
        rd(DAT_P, {8'h00, q[0]});
        rd(CNT, 16'h0002);
        bus16 <= 1'b1;
        wr(CTL, 16'h00F4);
        rd(CNT, 16'h0000);
        rd(CTL, 16'h0000);
        tk(K_OUT, 4'h1, ACK, 11'h000);
        sel(4'h1, 1'b1);
        wr(CTL, 16'h0010);
        tk(K_IN, 4'h1, NAK, 11'h000);
        wr(CTL, 16'h0008);
        tk(K_IN, 4'h1, DAT, 11'h003);
        host.tx(3, q);
        check({q[1], q[0]}, 16'hB2A1);
        check({8'h00, q[2]}, 16'h00C3);
        host.ack_in();
        for (int e = 4; e < 6; e++) begin
            sel(4'(e), 1'b1);
            wr(CTL, 16'h0001);
            rd(CTL, {15'h0000, e == 4});
            tk(K_IN, 4'(e), e == 4 ? STL : NAK, 11'h000);
        end
        sel(4'h0, 1'b1);
        tk(K_IN | 4'h1, 4'h0, NAK, 11'h000);
        wr(CTL, 16'h0002);
        rd(CTL, 16'h0002);
        tk(K_IN | 4'h1, 4'h0, DAT, 11'h000);
        rd(CTL, 16'h0000);
        wr(CTL, 16'h0002);
        tk(K_OUT | 4'h1, 4'h0, ACK, 11'h000);
        wr(CTL, 16'h0002);
        tk(4'h2, 4'h0, ACK, 11'h000);
        rd(CTL, 16'h0000);
        q = {};
        repeat (2) q.push_back(8'($urandom));
        host.rx(q, 1'b0);
        setup_sel <= 1'b1;
        rd(CNT, 16'h0002);
        rd(DAT_P, {q[1], q[0]});
        setup_sel <= 1'b0;
        auto_in(4'h2, 10);
        auto_in(4'h3, 6);
        test_done();
    end
endmodule
